// ### core/rivec_pkg.sv
`default_nettype none
package rivec_pkg;
    // Program word address width (8K words covers the flash)
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned NUM_SRC = 25;
    localparam int unsigned SRC_IDX_W = 5;

    // Reset entry and vector table base
    localparam logic [12:0] RESET_ADDR = 13'h0000;
    localparam logic [12:0] TABLE_BASE = 13'h0001;
    localparam logic [12:0] ADDR_RESET_VAL = 13'h0000;

    // Source index of each request; vector address is index plus TABLE_BASE, or plus bootStartAddr + TABLE_BASE when relocated
    localparam logic [4:0] SRC_EXT_REQUEST_ZERO   = 5'h00;
    localparam logic [4:0] SRC_EXT_REQUEST_ONE    = 5'h01;
    localparam logic [4:0] SRC_PIN_CHANGE_ZERO    = 5'h02;
    localparam logic [4:0] SRC_PIN_CHANGE_TWO     = 5'h04;
    localparam logic [4:0] SRC_WATCHDOG_TIMEOUT   = 5'h05;
    localparam logic [4:0] SRC_TIMER2_COMPA       = 5'h06;
    localparam logic [4:0] SRC_TIMER2_OVF         = 5'h08;
    localparam logic [4:0] SRC_TIMER1_CAPT        = 5'h09;
    localparam logic [4:0] SRC_TIMER1_OVF         = 5'h0c;
    localparam logic [4:0] SRC_TIMER0_COMPA       = 5'h0d;
    localparam logic [4:0] SRC_TIMER0_OVF         = 5'h0f;
    localparam logic [4:0] SRC_SPI_TRANSFER_DONE  = 5'h10;
    localparam logic [4:0] SRC_USART_RX           = 5'h11;
    localparam logic [4:0] SRC_USART_TX           = 5'h13;
    localparam logic [4:0] SRC_CONVERTER_DONE     = 5'h14;
    localparam logic [4:0] SRC_SELF_PROGRAM_READY = 5'h18;

    // Fuse encoding: 1 unprogrammed, 0 programmed
    localparam logic FUSE_UNPROGRAMMED = 1'b1;

    // Vector fetch handed to the core
    typedef struct packed {
        logic [12:0] addr;
        logic        isReset;
    } rivec_fetch_t;

    typedef enum logic [1:0] {
        RIVEC_RESET_FETCH,
        RIVEC_IDLE,
        RIVEC_WAIT_ACK
    } rivec_state_t;
endpackage
`default_nettype wire

// ### core/rivec_vector_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Any system reset sends core to vector one, 0x000 with fuse unprogrammed.
// - Vectors consecutive; external 0x001-0x002, pin change 0x003-0x005, watchdog 0x006.
// - Second 8-bit timer: compare A 0x007, compare B 0x008, overflow 0x009.
// - 16-bit timer: capture 0x00A, compare A 0x00B, B 0x00C, overflow 0x00D.
// - First 8-bit timer: compare A 0x00E, compare B 0x00F, overflow 0x010.
// - SPI done 0x011; serial receive 0x012, buffer empty 0x013, transmit 0x014.
// - Converter 0x015, memory ready 0x016, comparator 0x017, two-wire 0x018, self-program 0x019.
// - Programmed boot-reset fuse starts execution at boot loader address.
// - Relocate bit set adds boot section start to every interrupt vector address; the reset entry is unaffected.
// - Table starts 0x001 or boot address plus 0x001, independent of reset entry.
// - Fuse value 1 means unprogrammed, 0 means programmed.
// - A vector location is fetched only when its interrupt is taken.
module rivec_vector_unit (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // Configuration
    input  wire logic                    boot_reset_select_fuse,
    input  wire logic                    vector_relocate_select,
    input  wire logic [12:0]             bootStartAddr,
    // Requests from peripherals, already enabled
    input  wire logic [24:0]             irqPending,
    input  wire logic                    globalIntEnable,
    // Core side
    input  wire logic                    fetchAck,
    output logic                         fetchValid,
    output rivec_pkg::rivec_fetch_t      fetchOut,
    output logic [24:0]                  irqTaken
);

    rivec_pkg::rivec_state_t stateReg;
    logic                    winValid;
    logic [4:0]              winIdx;
    logic [12:0]             tableBase;
    logic [12:0]             resetEntry;

    // Lowest set bit wins; a fixed order keeps grants predictable
    function automatic logic [4:0] lowestSet(input logic [24:0] req);
        lowestSet = 5'h00;
        for (int i = rivec_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                lowestSet = 5'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address map

    assign resetEntry = (boot_reset_select_fuse == rivec_pkg::FUSE_UNPROGRAMMED) ?
                        rivec_pkg::RESET_ADDR : bootStartAddr;
    assign tableBase  = vector_relocate_select ? (bootStartAddr + rivec_pkg::TABLE_BASE)
                                               : rivec_pkg::TABLE_BASE;
    assign winValid   = globalIntEnable && (irqPending != 25'h0000000);
    assign winIdx     = lowestSet(irqPending);

    ////////////////////////////////////////////////////////////////////////
    // Fetch sequencing

    // Reset fetch first, then one vector per acknowledged interrupt
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= rivec_pkg::RIVEC_RESET_FETCH;
        end else begin
            case (stateReg)
                rivec_pkg::RIVEC_RESET_FETCH: begin
                    if (fetchAck) begin
                        stateReg <= rivec_pkg::RIVEC_IDLE;
                    end
                end
                rivec_pkg::RIVEC_IDLE: begin
                    if (winValid) begin
                        stateReg <= rivec_pkg::RIVEC_WAIT_ACK;
                    end
                end
                rivec_pkg::RIVEC_WAIT_ACK: begin
                    if (fetchAck) begin
                        stateReg <= rivec_pkg::RIVEC_IDLE;
                    end
                end
                default: stateReg <= rivec_pkg::RIVEC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetchValid       <= 1'b1;
            fetchOut.addr    <= rivec_pkg::ADDR_RESET_VAL;
            fetchOut.isReset <= 1'b1;
        end else begin
            case (stateReg)
                rivec_pkg::RIVEC_RESET_FETCH: begin
                    // Fuse may settle after reset release, so track it
                    fetchValid       <= !fetchAck;
                    fetchOut.addr    <= resetEntry;
                    fetchOut.isReset <= !fetchAck;
                end
                rivec_pkg::RIVEC_IDLE: begin
                    fetchValid       <= winValid;
                    fetchOut.addr    <= tableBase + {8'h00, winIdx};
                    fetchOut.isReset <= 1'b0;
                end
                rivec_pkg::RIVEC_WAIT_ACK: begin
                    fetchValid <= !fetchAck;
                end
                default: begin
                    fetchValid <= 1'b0;
                end
            endcase
        end
    end

    // One-cycle taken pulse lets the peripheral clear its flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqTaken <= 25'h0000000;
        end else begin
            irqTaken <= 25'h0000000;
            if (stateReg == rivec_pkg::RIVEC_IDLE && winValid) begin
                irqTaken[winIdx] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence seqGrant;
        stateReg == rivec_pkg::RIVEC_IDLE && winValid;
    endsequence

    // Core accepted the presented fetch at this edge
    sequence seqFetchAcked;
        fetchValid && fetchAck;
    endsequence

    AST_VECTOR_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
        seqGrant |=> fetchValid && !fetchOut.isReset && irqTaken == (25'h0000001 <<
            (fetchOut.addr - ($past(vector_relocate_select) ? $past(bootStartAddr) : 13'h0000) - 13'h0001)))
        else $error("vector address wrong");
    AST_NO_RELOC_BASE: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and !vector_relocate_select) |=> fetchOut.addr == 13'h0001 + {8'h00, $past(winIdx)})
        else $error("table base not 0x001");
    AST_WATCHDOG: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_WATCHDOG_TIMEOUT))
        |=> fetchOut.addr == 13'h0006)
        else $error("watchdog vector wrong");
    AST_TIMER2_OVF: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_TIMER2_OVF))
        |=> fetchOut.addr == 13'h0009)
        else $error("timer2 overflow vector wrong");
    AST_TIMER1_CAPT: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_TIMER1_CAPT))
        |=> fetchOut.addr == 13'h000a)
        else $error("timer1 capture vector wrong");
    AST_TIMER0_OVF: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_TIMER0_OVF))
        |=> fetchOut.addr == 13'h0010)
        else $error("timer0 overflow vector wrong");
    AST_SPI_DONE: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_SPI_TRANSFER_DONE))
        |=> fetchOut.addr == 13'h0011)
        else $error("transfer done vector wrong");
    AST_USART_TX: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_USART_TX))
        |=> fetchOut.addr == 13'h0014)
        else $error("transmit complete vector wrong");
    AST_CONVERTER: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_CONVERTER_DONE))
        |=> fetchOut.addr == 13'h0015)
        else $error("converter vector wrong");
    AST_SELF_PROG: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and (!vector_relocate_select && winIdx == rivec_pkg::SRC_SELF_PROGRAM_READY))
        |=> fetchOut.addr == 13'h0019)
        else $error("self-program vector wrong");
    AST_RELOC: assert property (@(posedge clk) disable iff (!arst_n)
        (seqGrant and vector_relocate_select)
        |=> fetchOut.addr == $past(bootStartAddr) + 13'h0001 + {8'h00, $past(winIdx)})
        else $error("relocated vector wrong");
    // Release edge still shows the reset value, hence arst_n in the antecedent
    // reset entry per fuse
    AST_RESET_ENTRY: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && stateReg == rivec_pkg::RIVEC_RESET_FETCH && !fetchAck
        |=> fetchOut.isReset && fetchOut.addr == ($past(boot_reset_select_fuse) ? 13'h0000 : $past(bootStartAddr)))
        else $error("reset entry wrong");
    AST_FETCH_CAUSE: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(fetchValid) && !fetchOut.isReset |-> $past(winValid) && irqTaken != 25'h0000000)
        else $error("vector fetched without taken interrupt");
    AST_DROP_AFTER_ACK: assert property (@(posedge clk) disable iff (!arst_n)
        seqFetchAcked |=> !fetchValid)
        else $error("fetch held after acceptance");
    AST_PRIORITY: assert property (@(posedge clk) disable iff (!arst_n)
        seqGrant |=> irqTaken == ($past(irqPending) & (~$past(irqPending) + 25'h0000001)))
        else $error("priority order wrong");
    AST_RESET_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
        stateReg == rivec_pkg::RIVEC_RESET_FETCH |-> fetchValid && fetchOut.isReset)
        else $error("reset vector skipped");
    AST_FUSE_ONE: assert property (@(posedge clk) disable iff (!arst_n)
        stateReg == rivec_pkg::RIVEC_RESET_FETCH && boot_reset_select_fuse && !fetchAck
        |=> fetchOut.addr == 13'h0000)
        else $error("unprogrammed fuse not at zero");

endmodule
`default_nettype wire

// ### verification/rivec_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: accepts each presented fetch after a chosen delay
module rivec_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Fetch handshake
    input  wire logic       fetchValid,
    input  wire logic [1:0] ackDelay,
    output logic            fetchAck
);
    logic [1:0] waitCnt;

    ////////////////////////////////////////////////////////////////
    // Ack lasts one cycle; holding it longer would accept the next grant unseen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitCnt  <= 2'h0;
            fetchAck <= 1'b0;
        end else if (fetchValid && !fetchAck && waitCnt >= ackDelay) begin
            waitCnt  <= 2'h0;
            fetchAck <= 1'b1;
        end else begin
            waitCnt  <= (fetchValid && !fetchAck) ? waitCnt + 2'h1 : 2'h0;
            fetchAck <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### verification/reset_irq_vector_addressing_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_irq_vector_addressing_test;
    logic                    clk = 1'b0;
    logic                    arst_n = 1'b0;
    logic                    boot_reset_select_fuse = 1'b1;
    logic                    vector_relocate_select = 1'b0;
    logic [12:0]             bootStartAddr = 13'h0000;
    logic [24:0]             irqPending = 25'h0000000;
    logic                    globalIntEnable = 1'b1;
    logic [1:0]              ackDelay = 2'h0;
    logic                    fetchAck;
    logic                    fetchValid;
    rivec_pkg::rivec_fetch_t fetchOut;
    logic [24:0]             irqTaken;
    logic [31:0]             seed = 32'h0000002a;
    logic [31:0]             r;
    int                      numErrors = 0;
    int                      checked = 0;

    rivec_vector_unit dut_u (.clk(clk), .arst_n(arst_n), .boot_reset_select_fuse(boot_reset_select_fuse),
        .vector_relocate_select(vector_relocate_select), .bootStartAddr(bootStartAddr),
        .irqPending(irqPending), .globalIntEnable(globalIntEnable), .fetchAck(fetchAck),
        .fetchValid(fetchValid), .fetchOut(fetchOut), .irqTaken(irqTaken));
    rivec_core_model core_u (.clk(clk), .arst_n(arst_n), .fetchValid(fetchValid), .ackDelay(ackDelay),
        .fetchAck(fetchAck));

    ////////////////////////////////////////////////////////////////
    // Free-running 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    // Repeatable xorshift source
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Vector word address of source idx
    function automatic logic [12:0] vec_addr(input int idx);
        return (vector_relocate_select ? bootStartAddr : 13'h0000) + 13'h0001 + 13'(idx);
    endfunction

    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Reset with a given configuration, then let the core take the entry
    task automatic do_reset(input logic f, input logic rel);
        logic [31:0] t;
        int          n;
        t = next_rand();
        @(posedge clk);
        arst_n <= 1'b0;
        irqPending <= 25'h0000000;
        boot_reset_select_fuse <= f;
        vector_relocate_select <= rel;
        bootStartAddr <= {t[4:0], 8'h00};
        ackDelay <= t[9:8];
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check({10'h000, fetchValid, fetchOut}, {10'h000, 1'b1, 13'h0000, 1'b1});
        @(negedge clk);
        check({11'h000, fetchOut}, {11'h000, f ? 13'h0000 : bootStartAddr, 1'b1});
        for (n = 0; n < 20 && fetchOut.isReset !== 1'b0; n++) @(negedge clk);
        check({24'h000000, fetchOut.isReset}, 25'h0000000);
    endtask

    // Raise a set of requests; peripheral drops each one as it is taken
    task automatic run_mask(input logic [24:0] m);
        logic [24:0] low;
        int          n;
        @(posedge clk);
        irqPending <= m;
        @(negedge clk);
        while (m != 25'h0000000) begin
            low = m & (~m + 25'h0000001);
            for (n = 0; n < 40 && irqTaken === 25'h0000000; n++) @(negedge clk);
            check(irqTaken, low);
            check({12'h000, fetchOut.addr}, {12'h000, vec_addr($clog2(low))});
            m = m & ~low;
            @(posedge clk);
            irqPending <= m;
            @(negedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // All four fuse and relocate settings, disabled then served
    initial begin
        for (int c = 0; c < 4; c++) begin
            do_reset(c[0], c[1]);
            @(posedge clk);
            globalIntEnable <= 1'b0;
            irqPending <= 25'h1ffffff;
            repeat (6) begin
                @(negedge clk);
                check({24'h000000, fetchValid}, 25'h0000000);
                check(irqTaken, 25'h0000000);
            end
            @(posedge clk);
            globalIntEnable <= 1'b1;
            irqPending <= 25'h0000000;
            run_mask(25'h1ffffff);
            repeat (3) begin
                r = next_rand();
                run_mask(r[24:0]);
            end
        end
        give_verdict();
    end

    // Hang guard: a full run needs about 1500 cycles, this allows 15000
    initial begin
        #60000;
        numErrors++;
        give_verdict();
    end
endmodule
`default_nettype wire
